// ==== verilog/dpa_device_end.sv ====
`include "dpa_map.svh"
`default_nettype none
// How it works
// - Respond only with both highs high, low low
// - Data lines undriven while not selected
// - Read high drives data, low stores byte
// - Reset clears all registers, lines become inputs
// - Direction bit one drives line, zero input
// - Control bit 2 picks output or direction
// - Host sets bit 2 before port access
// - Selects: port A, ctrl A, port B, ctrl B
// - Write latched, committed at phase trailing edge
// - Side A first line input sets bit 7
// - Control A bit 1 picks first edge
// - Bit 5 zero: second line input, flag 6
// - Mode 5=1,4=0,3=1: A pulses on port read
// - A handshake: port read drives second low
// - Bits 5,4 one: second line equals bit 3
// - Side B first edge sets bit 7, bit 0 edge
// - B pulse mode pulses on output write
// - B handshake: write, signal, peripheral acknowledges
// - Bits 6,7 hold readable line flags
// - Port read clears both side flags
// - Bit 0 gates flag 7, bit 3 flag 6
// - Requests active low, open drain
module dpa_device_end
  import dpa_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  dpa_link_if.dev link,
  input wire logic [PORT_W-1:0] portALinesIn,
  output logic [PORT_W-1:0] portALinesOut,
  output logic [PORT_W-1:0] portALinesOe,
  input wire logic [PORT_W-1:0] portBLinesIn,
  output logic [PORT_W-1:0] portBLinesOut,
  output logic [PORT_W-1:0] portBLinesOe,
  input wire logic aFirstControlLine,
  input wire logic aSecondControlLineIn,
  output logic aSecondControlLineOut,
  output logic aSecondControlLineOe,
  input wire logic bFirstControlLine,
  input wire logic bSecondControlLineIn,
  output logic bSecondControlLineOut,
  output logic bSecondControlLineOe
);

  // Registers are byte wide; nothing else can be served
  if (PORT_W != 8) begin : g_bad_width
    $error("dpa_device_end: PORT_W must be 8");
  end

  // Combined reset from local reset and the bus reset line
  logic clr;
  assign clr = ~rst_b | ~link.resetLow;

  // Chip select decode
  logic selected;
  assign selected = link.selectHighFirst & link.selectHighSecond & ~link.selectLow;

  // Phase clock edge detection, inputs are synchronous
  logic phasePrev_ff;
  logic phaseRise;
  logic phaseFall;
  assign phaseRise = link.busPhaseClock & ~phasePrev_ff;
  assign phaseFall = ~link.busPhaseClock & phasePrev_ff;

  // Access captured at the phase leading edge
  logic accValid_ff;
  logic [1:0] accRs_ff;
  logic accRnw_ff;
  logic [7:0] hold_ff;
  // Read drive registers
  logic [7:0] dataOut_ff;
  logic dataOe_ff;

  // Per-side views gathered for the read mux
  logic [7:0] ctrlW [2];
  logic [7:0] dirW [2];
  logic [7:0] outW [2];
  logic [7:0] pinIn [2];
  logic [7:0] viewW [2];
  logic firstIn [2];
  logic secondIn [2];
  logic secOutW [2];
  logic reqOeW [2];

  assign pinIn[0] = portALinesIn;
  assign pinIn[1] = portBLinesIn;
  assign firstIn[0] = aFirstControlLine;
  assign firstIn[1] = bFirstControlLine;
  assign secondIn[0] = aSecondControlLineIn;
  assign secondIn[1] = bSecondControlLineIn;

  // Read mux on the live register select lines
  logic [1:0] liveRs;
  logic liveSide;
  logic [7:0] readByte;
  assign liveRs = {link.regSelectHi, link.regSelectLo};
  assign liveSide = liveRs[1];
  assign readByte = liveRs[0] ? ctrlW[liveSide] :
    (ctrlW[liveSide][`DPA_CTL_PORT_SEL] ? viewW[liveSide] : dirW[liveSide]);

  // Bus capture, holding latch and read drive
  always_ff @(posedge clock) begin
    if (clr) begin
      phasePrev_ff <= 1'b0;
      accValid_ff <= 1'b0;
      accRs_ff <= 2'h0;
      accRnw_ff <= 1'b0;
      hold_ff <= `DPA_REG_RESET;
      dataOut_ff <= 8'h00;
      dataOe_ff <= 1'b0;
    end else begin
      phasePrev_ff <= link.busPhaseClock;
      // Leading edge: remember who is addressed
      if (phaseRise) begin
        accValid_ff <= selected;
        accRs_ff <= liveRs;
        accRnw_ff <= link.readNotWrite;
        // Write byte enters the holding latch
        if (selected & ~link.readNotWrite) begin
          hold_ff <= link.hostData;
        end
      end
      // Drive one cycle behind selected, reading, phase high
      dataOe_ff <= selected & link.readNotWrite & link.busPhaseClock;
      dataOut_ff <= readByte;
    end
  end

  assign link.hostDataDev = dataOut_ff;
  assign link.hostDataDevOe = dataOe_ff;

  for (genvar s = 0; s < 2; s++) begin : g_side
    // Side edge-select bit position for the first line
    localparam int EDGE_BIT = (s == 0) ? `DPA_CTL_A_FIRST_EDGE : `DPA_CTL_B_FIRST_EDGE;
    logic [7:0] ctrl_ff;
    logic [7:0] dir_ff;
    logic [7:0] out_ff;
    logic firstPrev_ff;
    logic secondPrev_ff;
    logic secOut_ff;
    logic reqOe_ff;
    logic nxt_secOut;
    logic firstEdge;
    logic secondEdge;
    logic sideHit;
    logic wrHit;
    logic portRead;
    logic portWrite;
    logic trigger;
    logic nxt_firstFlag;
    logic nxt_secFlag;

    // Active-edge detect, control bit picks polarity
    assign firstEdge = ctrl_ff[EDGE_BIT] ? (firstIn[s] & ~firstPrev_ff) :
      (~firstIn[s] & firstPrev_ff);
    assign secondEdge = ctrl_ff[`DPA_CTL_SEC_B4] ? (secondIn[s] & ~secondPrev_ff) :
      (~secondIn[s] & secondPrev_ff);

    // Access strobes at the phase trailing edge
    assign sideHit = phaseFall & accValid_ff & (accRs_ff[1] == 1'(s));
    assign wrHit = sideHit & ~accRnw_ff;
    assign portRead = sideHit & ~accRs_ff[0] & ctrl_ff[`DPA_CTL_PORT_SEL] & accRnw_ff;
    assign portWrite = sideHit & ~accRs_ff[0] & ctrl_ff[`DPA_CTL_PORT_SEL] & ~accRnw_ff;
    // Side A reacts to port reads, side B to port writes
    assign trigger = (s == 0) ? portRead : portWrite;

    // Flags: a new edge wins over a clearing read
    assign nxt_firstFlag = firstEdge | (ctrl_ff[`DPA_CTL_FIRST_FLAG] & ~portRead);
    assign nxt_secFlag = (secondEdge & ~ctrl_ff[`DPA_CTL_SEC_OUT]) |
      (ctrl_ff[`DPA_CTL_SEC_FLAG] & ~portRead);

    // Port read view: A shows pins, B shows output bits on outputs
    assign viewW[s] = (s == 0) ? pinIn[s] : ((out_ff & dir_ff) | (pinIn[s] & ~dir_ff));

    // Second control line output level
    always_comb begin
      if (!ctrl_ff[`DPA_CTL_SEC_OUT]) begin
        // Input mode, level parked high
        nxt_secOut = 1'b1;
      end else if (ctrl_ff[`DPA_CTL_SEC_B4]) begin
        nxt_secOut = ctrl_ff[`DPA_CTL_SEC_B3];
      end else if (trigger) begin
        nxt_secOut = 1'b0;
      end else if (ctrl_ff[`DPA_CTL_SEC_B3] ? phaseFall : firstEdge) begin
        // Pulse ends at next trailing edge, handshake on first-line edge
        nxt_secOut = 1'b1;
      end else begin
        nxt_secOut = secOut_ff;
      end
    end

    // Side registers, flags and outputs
    always_ff @(posedge clock) begin
      if (clr) begin
        ctrl_ff <= `DPA_REG_RESET;
        dir_ff <= `DPA_REG_RESET;
        out_ff <= `DPA_REG_RESET;
        firstPrev_ff <= 1'b0;
        secondPrev_ff <= 1'b0;
        secOut_ff <= 1'b0;
        reqOe_ff <= 1'b0;
      end else begin
        firstPrev_ff <= firstIn[s];
        secondPrev_ff <= secondIn[s];
        // Control write keeps flags, which software cannot set
        if (wrHit & accRs_ff[0]) begin
          ctrl_ff[5:0] <= hold_ff[5:0];
        end
        ctrl_ff[`DPA_CTL_FIRST_FLAG] <= nxt_firstFlag;
        ctrl_ff[`DPA_CTL_SEC_FLAG] <= nxt_secFlag;
        // Bit 2 at the trailing edge picks output or direction
        if (wrHit & ~accRs_ff[0] & ctrl_ff[`DPA_CTL_PORT_SEL]) begin
          out_ff <= hold_ff;
        end
        if (wrHit & ~accRs_ff[0] & ~ctrl_ff[`DPA_CTL_PORT_SEL]) begin
          dir_ff <= hold_ff;
        end
        secOut_ff <= nxt_secOut;
        // Enabled flags pull the shared request line low
        reqOe_ff <= (ctrl_ff[`DPA_CTL_FIRST_FLAG] & ctrl_ff[`DPA_CTL_FIRST_EN]) |
          (ctrl_ff[`DPA_CTL_SEC_FLAG] & ctrl_ff[`DPA_CTL_SEC_B3]);
      end
    end

    assign ctrlW[s] = ctrl_ff;
    assign dirW[s] = dir_ff;
    assign outW[s] = out_ff;
    assign secOutW[s] = secOut_ff;
    assign reqOeW[s] = reqOe_ff;
  end

  // Port pins: value from output register, enable from direction
  assign portALinesOut = outW[0];
  assign portALinesOe = dirW[0];
  assign portBLinesOut = outW[1];
  assign portBLinesOe = dirW[1];
  // Second lines drive only in output modes
  assign aSecondControlLineOut = secOutW[0];
  assign aSecondControlLineOe = ctrlW[0][`DPA_CTL_SEC_OUT];
  assign bSecondControlLineOut = secOutW[1];
  assign bSecondControlLineOe = ctrlW[1][`DPA_CTL_SEC_OUT];
  // Open-drain requests: enable means pull low
  assign link.sideARequestLowOe = reqOeW[0];
  assign link.sideBRequestLowOe = reqOeW[1];

endmodule
`default_nettype wire

// ==== verilog/dpa_map.svh ====
`ifndef DPA_MAP_SVH
`define DPA_MAP_SVH

// Register select codes on the two select lines
`define DPA_RS_PORT_A 2'h0
`define DPA_RS_CTRL_A 2'h1
`define DPA_RS_PORT_B 2'h2
`define DPA_RS_CTRL_B 2'h3

// Control register field positions
`define DPA_CTL_FIRST_EN 0
`define DPA_CTL_A_FIRST_EDGE 1
`define DPA_CTL_B_FIRST_EDGE 0
`define DPA_CTL_PORT_SEL 2
`define DPA_CTL_SEC_B3 3
`define DPA_CTL_SEC_B4 4
`define DPA_CTL_SEC_OUT 5
`define DPA_CTL_SEC_FLAG 6
`define DPA_CTL_FIRST_FLAG 7

// Reset value of every device register
`define DPA_REG_RESET 8'h00

// Controller register byte offsets on APB
`define DPA_APB_CMD 12'h000
`define DPA_APB_WDATA 12'h004
`define DPA_APB_STATUS 12'h008

// Controller command and status fields
`define DPA_CMD_RNW 8
`define DPA_STAT_BUSY 0

// Bus phase clock timing
`define DPA_CLOCK_MHZ 25
`define DPA_PHASE_HALF_NS 80
`define DPA_PHASE_HALF_CYC ((`DPA_PHASE_HALF_NS * `DPA_CLOCK_MHZ + 999) / 1000)

`endif

// ==== verilog/dpa_pkg.sv ====
`default_nettype none
package dpa_pkg;
  // Controller bus sequencer states
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SETUP,
    HS_HIGH,
    HS_HOLD
  } dpa_host_state_t;
endpackage
`default_nettype wire

// ==== verilog/dpa_link_if.sv ====
`default_nettype none
interface dpa_link_if;
  // Chip selects, phase clock and control from the controller
  logic selectHighFirst;
  logic selectHighSecond;
  logic selectLow;
  logic busPhaseClock;
  logic readNotWrite;
  logic regSelectLo;
  logic regSelectHi;
  logic resetLow;
  // Data bus halves and enables
  logic [7:0] hostDataHost;
  logic hostDataHostOe;
  logic [7:0] hostDataDev;
  logic hostDataDevOe;
  // Open-drain request pull-down enables
  logic sideARequestLowOe;
  logic sideBRequestLowOe;
  // Resolved wire levels; an undriven bus floats high
  logic [7:0] hostData;
  logic sideARequestLow;
  logic sideBRequestLow;

  assign hostData = hostDataDevOe ? hostDataDev : (hostDataHostOe ? hostDataHost : 8'hFF);
  assign sideARequestLow = ~sideARequestLowOe;
  assign sideBRequestLow = ~sideBRequestLowOe;

  modport dev (
    input selectHighFirst, selectHighSecond, selectLow, busPhaseClock, readNotWrite,
    input regSelectLo, regSelectHi, resetLow, hostData,
    output hostDataDev, hostDataDevOe, sideARequestLowOe, sideBRequestLowOe
  );
  modport host (
    output selectHighFirst, selectHighSecond, selectLow, busPhaseClock, readNotWrite,
    output regSelectLo, regSelectHi, resetLow, hostDataHost, hostDataHostOe,
    input hostData, sideARequestLow, sideBRequestLow
  );
endinterface
`default_nettype wire

// ==== verilog/dpa_host_end.sv ====
`include "dpa_map.svh"
`default_nettype none
module dpa_host_end
  import dpa_pkg::*;
#(
  parameter int HALF_CYC = `DPA_PHASE_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dpa_link_if.host link
);

  // Device needs at least two cycles of phase high to answer
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
    $error("dpa_host_end: HALF_CYC must be 2..255");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  dpa_host_state_t state_ff;
  logic [7:0] cnt_ff;
  logic start_ff;
  logic [1:0] cmdRs_ff;
  logic cmdRnw_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic selOn_ff;
  logic selLow_ff;
  logic phase_ff;
  logic dataOe_ff;
  logic resetLow_ff;

  // APB decode
  logic busy;
  logic setupPhase;
  logic wrTake;
  logic hitCmd;
  logic hitWdata;
  logic hitStatus;
  logic [31:0] statusWord;
  logic [31:0] readWord;
  assign busy = (state_ff != HS_IDLE) | start_ff;
  assign setupPhase = psel & ~penable;
  assign wrTake = psel & penable & pready_ff & pwrite;
  assign hitCmd = paddr == `DPA_APB_CMD;
  assign hitWdata = paddr == `DPA_APB_WDATA;
  assign hitStatus = paddr == `DPA_APB_STATUS;
  assign statusWord = {14'h0000, ~link.sideBRequestLow, ~link.sideARequestLow,
                       rdata_ff, 7'h00, busy};
  assign readWord = hitStatus ? statusWord :
    (hitWdata ? {24'h000000, wdata_ff} :
    (hitCmd ? {23'h000000, cmdRnw_ff, 6'h00, cmdRs_ff} : 32'h00000000));

  // APB slave: answers in the first access cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setupPhase;
      pslverr_ff <= setupPhase & ~(hitCmd | hitWdata | hitStatus);
      if (setupPhase) begin
        prdata_ff <= readWord;
      end
    end
  end

  // Command registers and bus sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= HS_IDLE;
      cnt_ff <= 8'h00;
      start_ff <= 1'b0;
      cmdRs_ff <= 2'h0;
      cmdRnw_ff <= 1'b0;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      selOn_ff <= 1'b0;
      selLow_ff <= 1'b1;
      phase_ff <= 1'b0;
      dataOe_ff <= 1'b0;
      resetLow_ff <= 1'b0;
    end else begin
      resetLow_ff <= 1'b1;
      // Writes while busy are dropped
      if (wrTake & hitWdata & ~busy) begin
        wdata_ff <= pwdata[7:0];
      end
      if (wrTake & hitCmd & ~busy) begin
        cmdRs_ff <= pwdata[1:0];
        cmdRnw_ff <= pwdata[`DPA_CMD_RNW];
        start_ff <= 1'b1;
      end
      unique case (state_ff)
        HS_IDLE: begin
          // Setup: selects, address and direction before phase rises
          if (start_ff) begin
            start_ff <= 1'b0;
            state_ff <= HS_SETUP;
            cnt_ff <= HALF_LAST;
            selOn_ff <= 1'b1;
            selLow_ff <= 1'b0;
            dataOe_ff <= ~cmdRnw_ff;
          end
        end
        HS_SETUP: begin
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h00) begin
            state_ff <= HS_HIGH;
            cnt_ff <= HALF_LAST;
            phase_ff <= 1'b1;
          end
        end
        HS_HIGH: begin
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h00) begin
            // Read data taken as phase falls
            state_ff <= HS_HOLD;
            cnt_ff <= HALF_LAST;
            phase_ff <= 1'b0;
            if (cmdRnw_ff) begin
              rdata_ff <= link.hostData;
            end
          end
        end
        HS_HOLD: begin
          // Hold address and data past the trailing edge
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h00) begin
            state_ff <= HS_IDLE;
            selOn_ff <= 1'b0;
            selLow_ff <= 1'b1;
            dataOe_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign link.selectHighFirst = selOn_ff;
  assign link.selectHighSecond = selOn_ff;
  assign link.selectLow = selLow_ff;
  assign link.busPhaseClock = phase_ff;
  assign link.readNotWrite = cmdRnw_ff;
  assign link.regSelectLo = cmdRs_ff[0];
  assign link.regSelectHi = cmdRs_ff[1];
  assign link.resetLow = resetLow_ff;
  assign link.hostDataHost = wdata_ff;
  assign link.hostDataHostOe = dataOe_ff;

endmodule
`default_nettype wire

// ==== sim/dpa_link_properties.sv ====
`default_nettype none
module dpa_link_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic selectHighFirst,
  input wire logic selectHighSecond,
  input wire logic selectLow,
  input wire logic busPhaseClock,
  input wire logic readNotWrite,
  input wire logic regSelectLo,
  input wire logic regSelectHi,
  input wire logic resetLow,
  input wire logic [7:0] hostDataHost,
  input wire logic hostDataHostOe,
  input wire logic hostDataDevOe,
  input wire logic sideARequestLowOe,
  input wire logic sideBRequestLowOe
);
  // Chip is selected with both highs high and the low select low
  wire logic chipSel = selectHighFirst && selectHighSecond && !selectLow;
  // Port reads of each side, as seen on the link
  wire logic portARead = chipSel && readNotWrite && !regSelectHi && !regSelectLo;
  wire logic portBRead = chipSel && readNotWrite && regSelectHi && !regSelectLo;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Device drives data only while selected
  property p_dev_oe_sel;
    hostDataDevOe |-> chipSel;
  endproperty
  a_dev_oe_sel: assert property (p_dev_oe_sel) else $error("data driven unselected");
  // Device drives data only for reads, never against the host
  property p_dev_oe_read;
    hostDataDevOe |-> readNotWrite && !hostDataHostOe;
  endproperty
  a_dev_oe_read: assert property (p_dev_oe_read) else $error("data driven on write");
  // Link reset leaves the bus and requests released
  property p_reset_quiet;
    !resetLow |=> !hostDataDevOe && !sideARequestLowOe && !sideBRequestLowOe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
  // Phase clock high for two cycles per access
  property p_phase_len;
    $rose(busPhaseClock) |-> busPhaseClock[*2] ##1 !busPhaseClock;
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("phase pulse length wrong");
  // Read data window sits across the phase trailing edge
  property p_oe_window;
    $rose(hostDataDevOe) |-> busPhaseClock ##1 hostDataDevOe && !busPhaseClock
      ##1 !hostDataDevOe;
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("read data window wrong");
  // Selection and direction are steady while phase is high
  property p_sel_stable;
    busPhaseClock |-> chipSel && $stable({readNotWrite, regSelectLo, regSelectHi});
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("selection moved in phase");
  // Write byte steady while phase is high
  property p_wr_data;
    busPhaseClock && !readNotWrite |-> hostDataHostOe && $stable(hostDataHost);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write byte moved in phase");
  // Selection held past the trailing edge
  property p_hold_after;
    $fell(busPhaseClock) |-> chipSel[*2];
  endproperty
  a_hold_after: assert property (p_hold_after) else $error("selection dropped early");
  // Side A request released only after a side A port read
  property p_req_clr_a;
    $fell(sideARequestLowOe) |-> $past(portARead, 2);
  endproperty
  a_req_clr_a: assert property (p_req_clr_a) else $error("side A request dropped");
  // Side B request released only after a side B port read
  property p_req_clr_b;
    $fell(sideBRequestLowOe) |-> $past(portBRead, 2);
  endproperty
  a_req_clr_b: assert property (p_req_clr_b) else $error("side B request dropped");

  // Main traffic kinds
  c_write: cover property (busPhaseClock && !readNotWrite);
  c_read: cover property ($rose(hostDataDevOe));
  c_req_a: cover property ($rose(sideARequestLowOe));
  c_req_b: cover property ($rose(sideBRequestLowOe));
endmodule
`default_nettype wire

// ==== sim/dual_port_parallel_adapter_tb.sv ====
`include "dpa_map.svh"
`default_nettype none
module dual_port_parallel_adapter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and APB request
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Peripheral stimulus and device outputs
  logic [7:0] extA = 8'h3C;
  logic [7:0] extB = 8'hC3;
  logic aFirst = 1'b0;
  logic aSecIn = 1'b1;
  logic bFirst = 1'b0;
  logic [7:0] aOut, aOe, bOut, bOe;
  logic aSecOut, aSecOe, bSecOut, bSecOe;
  // Pins: driven bits from the device, the rest from the peripheral
  wire [7:0] aPins = (aOe & aOut) | (~aOe & extA);
  wire [7:0] bPins = (bOe & bOut) | (~bOe & extB);
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] b;
  logic [31:0] r;
  logic e;
  // Ordinary rows: select code, byte written, byte read back
  typedef struct packed {logic [1:0] rs; logic [7:0] wr; logic [7:0] rd;} dpa_row_t;
  dpa_row_t rows [8] = '{'{2'h1, 8'h00, 8'h00}, '{2'h0, 8'hF0, 8'hF0},
    '{2'h1, 8'h04, 8'h04}, '{2'h0, 8'hA5, 8'hAC}, '{2'h3, 8'h00, 8'h00},
    '{2'h2, 8'h0F, 8'h0F}, '{2'h3, 8'h04, 8'h04}, '{2'h2, 8'h5A, 8'hCA}};

  dpa_link_if link ();
  dpa_host_end #(.HALF_CYC(2)) u_dpa_host_end (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  dpa_device_end #(.PORT_W(8)) u_dpa_device_end (.clock(clock), .rst_b(rst_b),
    .link(link.dev), .portALinesIn(aPins), .portALinesOut(aOut), .portALinesOe(aOe),
    .portBLinesIn(bPins), .portBLinesOut(bOut), .portBLinesOe(bOe),
    .aFirstControlLine(aFirst), .aSecondControlLineIn(aSecIn),
    .aSecondControlLineOut(aSecOut), .aSecondControlLineOe(aSecOe),
    .bFirstControlLine(bFirst), .bSecondControlLineIn(1'b1),
    .bSecondControlLineOut(bSecOut), .bSecondControlLineOe(bSecOe));
  dpa_link_properties u_props (.clock(clock), .rst_b(rst_b),
    .selectHighFirst(link.selectHighFirst), .selectHighSecond(link.selectHighSecond),
    .selectLow(link.selectLow), .busPhaseClock(link.busPhaseClock),
    .readNotWrite(link.readNotWrite), .regSelectLo(link.regSelectLo),
    .regSelectHi(link.regSelectHi), .resetLow(link.resetLow),
    .hostDataHost(link.hostDataHost), .hostDataHostOe(link.hostDataHostOe),
    .hostDataDevOe(link.hostDataDevOe), .sideARequestLowOe(link.sideARequestLowOe),
    .sideBRequestLowOe(link.sideBRequestLowOe));

  // 25 MHz clock
  always #20 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // One device access through the controller, waiting until idle
  task automatic dev(input logic rnw, input logic [1:0] rs, input logic [7:0] wd,
                     output logic [7:0] rd);
    logic [31:0] s;
    logic x;
    if (!rnw) apb(1'b1, `DPA_APB_WDATA, {24'h0, wd}, s, x);
    apb(1'b1, `DPA_APB_CMD, {23'h0, rnw, 6'h0, rs}, s, x);
    // Poll busy; a hang is caught by the hang guard
    do begin
      apb(1'b0, `DPA_APB_STATUS, 32'h0, s, x);
    end while (s[0] !== 1'b0);
    rd = s[15:8];
  endtask

  // Let a control line edge reach the flags and requests
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask

  // Verdict
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      dev(1'b1, i[1:0], 8'h00, b);
      check(b, 8'h00);
    end
    foreach (rows[i]) begin
      dev(1'b0, rows[i].rs, rows[i].wr, b);
      dev(1'b1, rows[i].rs, 8'h00, b);
      check(b, rows[i].rd);
    end
    check(aOe, 8'hF0);
    check(aOut, 8'hA5);
    check(bOe, 8'h0F);
    check(bOut, 8'h5A);
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    // Side A first line, rising edge, request enabled
    dev(1'b0, 2'h1, 8'h07, b);
    aFirst <= 1'b1;
    settle();
    check(link.sideARequestLow, 1'b0);
    apb(1'b0, `DPA_APB_STATUS, 32'h0, r, e);
    check(r[16], 1'b1);
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h87);
    dev(1'b1, 2'h0, 8'h00, b);
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h07);
    check(link.sideARequestLow, 1'b1);
    aFirst <= 1'b0;
    settle();
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h07);
    // Flag set but request masked
    dev(1'b0, 2'h1, 8'h06, b);
    aFirst <= 1'b1;
    settle();
    check(link.sideARequestLow, 1'b1);
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h86);
    dev(1'b1, 2'h0, 8'h00, b);
    // Second line as input, falling then rising edge
    dev(1'b0, 2'h1, 8'h0D, b);
    aSecIn <= 1'b0;
    settle();
    check(link.sideARequestLow, 1'b0);
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h4D);
    dev(1'b1, 2'h0, 8'h00, b);
    dev(1'b0, 2'h1, 8'h1D, b);
    aSecIn <= 1'b1;
    settle();
    dev(1'b1, 2'h1, 8'h00, b);
    check(b, 8'h5D);
    dev(1'b1, 2'h0, 8'h00, b);
    // Static output follows bit 3
    dev(1'b0, 2'h1, 8'h3C, b);
    check({aSecOe, aSecOut}, 2'h3);
    dev(1'b0, 2'h1, 8'h34, b);
    check({aSecOe, aSecOut}, 2'h2);
    // Handshake: low after port read, high on falling first-line edge
    dev(1'b0, 2'h1, 8'h24, b);
    dev(1'b1, 2'h0, 8'h00, b);
    check(aSecOut, 1'b0);
    dev(1'b1, 2'h1, 8'h00, b);
    check(aSecOut, 1'b0);
    aFirst <= 1'b0;
    settle();
    check(aSecOut, 1'b1);
    // Pulse: low after port read until the next access ends
    dev(1'b0, 2'h1, 8'h2C, b);
    dev(1'b1, 2'h0, 8'h00, b);
    check(aSecOut, 1'b0);
    dev(1'b1, 2'h1, 8'h00, b);
    check(aSecOut, 1'b1);
    // Side B first line, rising edge selected by bit 0
    dev(1'b0, 2'h3, 8'h05, b);
    bFirst <= 1'b1;
    settle();
    check(link.sideBRequestLow, 1'b0);
    apb(1'b0, `DPA_APB_STATUS, 32'h0, r, e);
    check(r[17], 1'b1);
    dev(1'b1, 2'h3, 8'h00, b);
    check(b, 8'h85);
    dev(1'b1, 2'h2, 8'h00, b);
    dev(1'b1, 2'h3, 8'h00, b);
    check(b, 8'h05);
    // Side B pulse on port write
    dev(1'b0, 2'h3, 8'h2C, b);
    dev(1'b0, 2'h2, 8'h33, b);
    check({bSecOe, bSecOut}, 2'h2);
    dev(1'b1, 2'h3, 8'h00, b);
    check(bSecOut, 1'b1);
    // Side B handshake: write, then peripheral falling edge
    dev(1'b0, 2'h3, 8'h24, b);
    dev(1'b0, 2'h2, 8'hC4, b);
    check(bSecOut, 1'b0);
    check(bOut, 8'hC4);
    bFirst <= 1'b0;
    settle();
    check(bSecOut, 1'b1);
    // Second reset mid-run
    rst_b <= 1'b0;
    repeat (8) @(posedge clock);
    check({aOe, bOe, aSecOe, bSecOe}, 18'h0);
    rst_b <= 1'b1;
    @(posedge clock);
    dev(1'b1, 2'h3, 8'h00, b);
    check(b, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
